// File: bench/hsc_line_peer.sv
// Line-side peer buffers and bias network shared with the device
`timescale 1ns/10ps
`default_nettype none
module hsc_line_peer (
    input wire logic [2:0] i_dev_plus_oe,
    input wire logic [2:0] i_dev_minus_oe,
    input wire logic [2:0] i_peer_low,
    output logic [2:0] o_plus,
    output logic [2:0] o_minus
);
    logic [2:0] pulled;
    // Any driver reverses a pair; the bias puts plus above minus once all let go
    assign pulled = i_dev_plus_oe | i_dev_minus_oe | i_peer_low;
    assign o_plus = ~pulled;
    assign o_minus = pulled;
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the hot-swap connect controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import hsc_pkg::*;
    logic i_clk = 1'b0;
    logic i_line_clk = 1'b0;
    logic i_reset = 1'b1;
    logic en = 1'b0;
    logic sup_a = 1'b0;
    logic sup_b = 1'b0;
    logic term = 1'b0;
    logic [2:0] card_low = 3'h0;
    logic [2:0] peer_low = 3'h0;
    logic [2:0] card_oe, card_w, lp_oe, lm_oe, lp, lm;
    logic plug_oe, ready_oe;
    logic [2:0] card_o, lp_o, lm_o;
    logic plug_o, ready_o;
    logic [7:0] mon;
    int mismatches = 0;
    int check_count = 0;
    int cyc = 0;
    int n;

    initial forever #20 i_clk = ~i_clk;
    initial forever #16 i_line_clk = ~i_line_clk;

    assign card_w = ~(card_oe | card_low);
    assign mon = {ready_oe, plug_oe, card_oe, lp_oe};

    hsc_connect #(.POWER_SETTLE(20), .TERM_SETTLE(40)) i_hsc_connect (
        .i_clk(i_clk), .i_reset(i_reset), .i_line_clk(i_line_clk), .i_enable(en),
        .i_supply_a_good(sup_a), .i_supply_b_good(sup_b),
        .i_term_minus_low(term), .i_term_plus_high(term),
        .i_card_clock(card_w[0]), .o_card_clock_o(card_o[0]), .o_card_clock_oe(card_oe[0]),
        .i_card_data(card_w[1]), .o_card_data_o(card_o[1]), .o_card_data_oe(card_oe[1]),
        .i_card_sideband(card_w[2]), .o_card_sideband_o(card_o[2]),
        .o_card_sideband_oe(card_oe[2]),
        .i_line_clock_plus(lp[0]), .o_line_clock_plus_o(lp_o[0]),
        .o_line_clock_plus_oe(lp_oe[0]),
        .i_line_clock_minus(lm[0]), .o_line_clock_minus_o(lm_o[0]),
        .o_line_clock_minus_oe(lm_oe[0]),
        .i_line_data_plus(lp[1]), .o_line_data_plus_o(lp_o[1]), .o_line_data_plus_oe(lp_oe[1]),
        .i_line_data_minus(lm[1]), .o_line_data_minus_o(lm_o[1]),
        .o_line_data_minus_oe(lm_oe[1]),
        .i_line_sideband_plus(lp[2]), .o_line_sideband_plus_o(lp_o[2]),
        .o_line_sideband_plus_oe(lp_oe[2]),
        .i_line_sideband_minus(lm[2]), .o_line_sideband_minus_o(lm_o[2]),
        .o_line_sideband_minus_oe(lm_oe[2]),
        .o_plug_in_detect_n_o(plug_o), .o_plug_in_detect_n_oe(plug_oe),
        .o_ready_o(ready_o), .o_ready_oe(ready_oe)
    );

    hsc_line_peer i_hsc_line_peer (
        .i_dev_plus_oe(lp_oe), .i_dev_minus_oe(lm_oe), .i_peer_low(peer_low),
        .o_plus(lp), .o_minus(lm)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge i_clk);
    endtask

    // Waits a bounded number of cycles for one monitored bit to reach a level
    task automatic wait_bit(input int b, input logic v, input int lim, output int cnt);
        cnt = 0;
        while (mon[b] !== v && cnt < lim) begin
            @(posedge i_clk);
            cnt++;
        end
        // Returns on the clock edge so the next stimulus lands on an edge too
        check(mon[b], v);
    endtask

    task automatic report_and_stop;
        if (mismatches == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 6000) begin
            mismatches++;
            report_and_stop();
        end
    end

    initial begin
        idle(16);
        check(mon, 8'h00);
        i_reset <= 1'b0;
        idle(2);
        sup_a <= 1'b1;
        sup_b <= 1'b1;
        idle(60);
        check(mon, 8'h00);
        term <= 1'b1;
        wait_bit(6, 1'b1, 80, n);
        check(8'(n >= 35), 8'h01);
        idle(300);
        check(mon, 8'h40);
        // Line activity with enable low, then enable while quiet: full idle time applies
        peer_low[0] <= 1'b1;
        idle(20);
        peer_low[0] <= 1'b0;
        en <= 1'b1;
        wait_bit(7, 1'b1, 320, n);
        check(8'(n >= 240), 8'h01);
        check({6'h00, plug_o, ready_o}, 8'h00);
        // Channel direction for clock, data and sideband
        for (int c = 0; c < 3; c++) begin
            card_low[c] <= 1'b1;
            wait_bit(c, 1'b1, 20, n);
            check(8'(card_oe[c]), 8'h00);
            check(8'(lm_oe[c]), 8'h01);
            check({6'h00, lp_o[c], lm_o[c]}, 8'h01);
            card_low[c] <= 1'b0;
            wait_bit(c, 1'b0, 30, n);
            idle(20);
            peer_low[c] <= 1'b1;
            wait_bit(3 + c, 1'b1, 30, n);
            check(8'(lp_oe[c]), 8'h00);
            check(8'(card_o[c]), 8'h00);
            peer_low[c] <= 1'b0;
            wait_bit(3 + c, 1'b0, 40, n);
            idle(20);
        end
        en <= 1'b0;
        wait_bit(7, 1'b0, 10, n);
        idle(300);
        check(mon, 8'h40);
        // Re-enable while idle, then a start and a stop on the line connect early
        peer_low[0] <= 1'b1;
        idle(20);
        peer_low[0] <= 1'b0;
        en <= 1'b1;
        idle(40);
        peer_low[1] <= 1'b1;
        idle(20);
        peer_low[1] <= 1'b0;
        wait_bit(7, 1'b1, 40, n);
        // Supply loss breaks the connection and reruns start-up
        sup_a <= 1'b0;
        wait_bit(7, 1'b0, 10, n);
        check(8'(plug_oe), 8'h00);
        sup_a <= 1'b1;
        wait_bit(6, 1'b1, 100, n);
        check(8'(n >= 55), 8'h01);
        wait_bit(7, 1'b1, 320, n);
        report_and_stop();
    end
endmodule
`default_nettype wire

// File: logic/hsc_connect.sv
// Hot-swap start-up, connect decision and channel direction control
//
// Operation
// - Enable low: stay isolated, ready released
// - Join only after stop or idle seen
// - Plug-in detect low once steadily plugged, powered
// - Ready released whenever sides are disconnected
// - Ready low only enabled, plugged, connected
// - All pin drivers off until start-up done
// - First timer, then check line termination
// - Valid termination starts second timer
// - Connect on idle time or stop seen
// - Loss breaks connection, reruns full start-up
// - Sideband channel behaves like clock and data
// - Line state from plus/minus polarity only
// - Each channel picks its own direction
`timescale 1ns/10ps
`default_nettype none
module hsc_connect #(
    parameter int POWER_SETTLE = hsc_pkg::POWER_SETTLE_CYC,
    parameter int TERM_SETTLE = hsc_pkg::TERM_SETTLE_CYC
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_line_clk,
    input wire logic i_enable,
    input wire logic i_supply_a_good,
    input wire logic i_supply_b_good,
    input wire logic i_term_minus_low,
    input wire logic i_term_plus_high,
    input wire logic i_card_clock,
    output logic o_card_clock_o,
    output logic o_card_clock_oe,
    input wire logic i_card_data,
    output logic o_card_data_o,
    output logic o_card_data_oe,
    input wire logic i_card_sideband,
    output logic o_card_sideband_o,
    output logic o_card_sideband_oe,
    input wire logic i_line_clock_plus,
    output logic o_line_clock_plus_o,
    output logic o_line_clock_plus_oe,
    input wire logic i_line_clock_minus,
    output logic o_line_clock_minus_o,
    output logic o_line_clock_minus_oe,
    input wire logic i_line_data_plus,
    output logic o_line_data_plus_o,
    output logic o_line_data_plus_oe,
    input wire logic i_line_data_minus,
    output logic o_line_data_minus_o,
    output logic o_line_data_minus_oe,
    input wire logic i_line_sideband_plus,
    output logic o_line_sideband_plus_o,
    output logic o_line_sideband_plus_oe,
    input wire logic i_line_sideband_minus,
    output logic o_line_sideband_minus_o,
    output logic o_line_sideband_minus_oe,
    output logic o_plug_in_detect_n_o,
    output logic o_plug_in_detect_n_oe,
    output logic o_ready_o,
    output logic o_ready_oe
);
    import hsc_pkg::*;
    localparam logic [TIMER_W-1:0] POWER_LAST = TIMER_W'(POWER_SETTLE - 1);
    localparam logic [TIMER_W-1:0] TERM_LAST = TIMER_W'(TERM_SETTLE - 1);
    localparam logic [TIMER_W-1:0] IDLE_CNT = TIMER_W'(BUS_IDLE_CYC);
    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYC - 1);
    typedef struct packed {
        logic [SY_W-1:0] s1;
        logic [SY_W-1:0] s2;
        logic [SY_W-1:0] s3;
        logic [SY_W-1:0] f;
        logic stop_prev;
        hsc_state_t state;
        logic [TIMER_W-1:0] timer;
        logic [TIMER_W-1:0] idle_cnt;
        logic stop_seen;
        hsc_dir_t [NCH-1:0] dir;
        logic [NCH-1:0][HOLD_W-1:0] hold;
        logic [NCH-1:0] card_oe;
        logic [NCH-1:0] line_oe;
        logic plug_oe;
        logic ready_oe;
        logic low_lvl;
        logic high_lvl;
    } hsc_top_s_t;
    localparam hsc_top_s_t TOP_RST = '{s1: SY_RST, s2: SY_RST, s3: SY_RST, f: SY_RST,
                                       stop_prev: 1'b0, state: HSC_POWER, timer: '0,
                                       idle_cnt: '0, stop_seen: 1'b0,
                                       dir: '{default: HSC_DIR_IDLE}, hold: '0, card_oe: '0,
                                       line_oe: '0, plug_oe: 1'b0, ready_oe: 1'b0,
                                       low_lvl: 1'b0, high_lvl: 1'b1};
    // Keep the change only once the last two synchroniser stages agree
    function automatic logic [SY_W-1:0] filt(input logic [SY_W-1:0] a,
                                             input logic [SY_W-1:0] b,
                                             input logic [SY_W-1:0] f);
        filt = (~(a ^ b) & b) | ((a ^ b) & f);
    endfunction
    hsc_top_s_t s_q;
    hsc_top_s_t s_d;
    logic [NCH-1:0] rx_level;
    logic rx_stop_toggle;
    logic en;
    logic supply_ok;
    logic term_ok;
    logic idle_hit;
    logic stop_ev;
    logic [NCH-1:0] card_lv;
    logic [NCH-1:0] line_lv;
    hsc_line_rx u_line_rx (
        .i_line_clk(i_line_clk),
        .i_reset(i_reset),
        .i_line_pins({i_line_sideband_minus, i_line_sideband_plus, i_line_data_minus,
                      i_line_data_plus, i_line_clock_minus, i_line_clock_plus}),
        .o_line_level(rx_level),
        .o_stop_toggle(rx_stop_toggle)
    );
    assign en = s_q.f[SY_EN];
    assign supply_ok = s_q.f[SY_SUPA] & s_q.f[SY_SUPB];
    // Comparators flag minus below 0.9 and plus above 0.1 of the line supply
    assign term_ok = s_q.f[SY_TERM_M] & s_q.f[SY_TERM_P];
    assign idle_hit = s_q.idle_cnt >= IDLE_CNT;
    assign stop_ev = s_q.f[SY_STOP] ^ s_q.stop_prev;
    assign card_lv = s_q.f[SY_CARD +: NCH];
    assign line_lv = s_q.f[SY_LINE +: NCH];
    always_comb begin
        s_d = s_q;
        // Pins and the line domain both arrive through three stages
        s_d.s1 = {rx_stop_toggle, rx_level, i_card_sideband, i_card_data, i_card_clock,
                  i_term_plus_high, i_term_minus_low, i_supply_b_good, i_supply_a_good,
                  i_enable};
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        s_d.f = filt(s_q.s2, s_q.s3, s_q.f);
        s_d.stop_prev = s_q.f[SY_STOP];
        if (line_lv[CH_CLOCK] && line_lv[CH_DATA]) begin
            if (!idle_hit) begin
                s_d.idle_cnt = s_q.idle_cnt + 1'b1;
            end
        end else begin
            s_d.idle_cnt = '0;
        end
        case (s_q.state)
            HSC_POWER: begin
                // References settle on stable supplies before the first interval runs
                if (!supply_ok) begin
                    s_d.timer = '0;
                end else if (s_q.timer == POWER_LAST) begin
                    s_d.timer = '0;
                    s_d.state = HSC_CHECK;
                end else begin
                    s_d.timer = s_q.timer + 1'b1;
                end
            end
            HSC_CHECK: begin
                if (!supply_ok) begin
                    s_d.state = HSC_POWER;
                end else if (term_ok) begin
                    s_d.timer = '0;
                    s_d.state = HSC_SETTLE;
                end
            end
            HSC_SETTLE: begin
                if (!supply_ok) begin
                    s_d.timer = '0;
                    s_d.state = HSC_POWER;
                end else if (!term_ok) begin
                    s_d.state = HSC_CHECK;
                end else if (s_q.timer == TERM_LAST) begin
                    s_d.state = HSC_ARMED;
                end else begin
                    s_d.timer = s_q.timer + 1'b1;
                end
            end
            HSC_ARMED: begin
                if (!supply_ok || !term_ok) begin
                    s_d.timer = '0;
                    s_d.state = HSC_POWER;
                end else if (en && (idle_hit || (card_lv[CH_CLOCK] && card_lv[CH_DATA]
                                                 && (s_q.stop_seen || stop_ev)))) begin
                    s_d.state = HSC_CONN;
                end
            end
            HSC_CONN: begin
                if (!supply_ok || !term_ok) begin
                    s_d.timer = '0;
                    s_d.state = HSC_POWER;
                end else if (!en) begin
                    // Dropping enable mid-transfer may hang the bus; system avoids it
                    s_d.state = HSC_ARMED;
                end
            end
            default: begin
                s_d.state = HSC_POWER;
            end
        endcase
        // A stop in the same cycle as leaving the armed state is not kept
        if (s_d.state != HSC_ARMED) begin
            s_d.stop_seen = 1'b0;
        end
        if (s_q.state == HSC_ARMED && s_d.state == HSC_ARMED && stop_ev) begin
            s_d.stop_seen = 1'b1;
        end

        // Every channel, sideband included, follows bus activity on its own
        for (int i = 0; i < NCH; i++) begin
            if (s_d.state != HSC_CONN) begin
                s_d.dir[i] = HSC_DIR_IDLE;
                s_d.hold[i] = '0;
            end else begin
                case (s_q.dir[i])
                    HSC_DIR_IDLE: begin
                        if (!card_lv[i]) begin
                            s_d.dir[i] = HSC_DIR_TO_LINE;
                        end else if (!line_lv[i]) begin
                            s_d.dir[i] = HSC_DIR_TO_CARD;
                        end
                    end
                    HSC_DIR_TO_LINE: begin
                        if (card_lv[i]) begin
                            s_d.dir[i] = HSC_DIR_HOLD_LINE;
                            s_d.hold[i] = '0;
                        end
                    end
                    HSC_DIR_TO_CARD: begin
                        if (line_lv[i]) begin
                            s_d.dir[i] = HSC_DIR_HOLD_CARD;
                            s_d.hold[i] = '0;
                        end
                    end
                    // Blanking stops our own released low from echoing back
                    HSC_DIR_HOLD_LINE: begin
                        s_d.hold[i] = s_q.hold[i] + 1'b1;
                        if (line_lv[i] || s_q.hold[i] == HOLD_LAST) begin
                            s_d.dir[i] = HSC_DIR_IDLE;
                        end
                    end
                    HSC_DIR_HOLD_CARD: begin
                        s_d.hold[i] = s_q.hold[i] + 1'b1;
                        if (card_lv[i] || s_q.hold[i] == HOLD_LAST) begin
                            s_d.dir[i] = HSC_DIR_IDLE;
                        end
                    end
                    default: begin
                        s_d.dir[i] = HSC_DIR_IDLE;
                    end
                endcase
            end
            s_d.line_oe[i] = s_d.dir[i] == HSC_DIR_TO_LINE;
            s_d.card_oe[i] = s_d.dir[i] == HSC_DIR_TO_CARD;
        end

        s_d.plug_oe = s_d.state == HSC_ARMED || s_d.state == HSC_CONN;
        s_d.ready_oe = s_d.state == HSC_CONN && en && s_d.plug_oe;
        s_d.low_lvl = 1'b0;
        s_d.high_lvl = 1'b1;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s_q <= TOP_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Open-drain card side pulls low; a line low drives plus low and minus high
    assign o_card_clock_o = s_q.low_lvl;
    assign o_card_clock_oe = s_q.card_oe[CH_CLOCK];
    assign o_card_data_o = s_q.low_lvl;
    assign o_card_data_oe = s_q.card_oe[CH_DATA];
    assign o_card_sideband_o = s_q.low_lvl;
    assign o_card_sideband_oe = s_q.card_oe[CH_SIDE];
    assign o_line_clock_plus_o = s_q.low_lvl;
    assign o_line_clock_plus_oe = s_q.line_oe[CH_CLOCK];
    assign o_line_clock_minus_o = s_q.high_lvl;
    assign o_line_clock_minus_oe = s_q.line_oe[CH_CLOCK];
    assign o_line_data_plus_o = s_q.low_lvl;
    assign o_line_data_plus_oe = s_q.line_oe[CH_DATA];
    assign o_line_data_minus_o = s_q.high_lvl;
    assign o_line_data_minus_oe = s_q.line_oe[CH_DATA];
    assign o_line_sideband_plus_o = s_q.low_lvl;
    assign o_line_sideband_plus_oe = s_q.line_oe[CH_SIDE];
    assign o_line_sideband_minus_o = s_q.high_lvl;
    assign o_line_sideband_minus_oe = s_q.line_oe[CH_SIDE];
    assign o_plug_in_detect_n_o = s_q.low_lvl;
    assign o_plug_in_detect_n_oe = s_q.plug_oe;
    assign o_ready_o = s_q.low_lvl;
    assign o_ready_oe = s_q.ready_oe;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_join;
        s_q.state != HSC_CONN ##1 s_q.state == HSC_CONN;
    endsequence

    sequence s_armed_idle;
        s_q.state == HSC_ARMED && en && supply_ok && term_ok && idle_hit;
    endsequence

    AST_EN_LOW_RELEASES: assert property (!en |=> !o_ready_oe && s_q.state != HSC_CONN)
        else $error("ready or connection held with enable low");
    AST_JOIN_FROM_ARMED: assert property (s_join |-> $past(s_q.state) == HSC_ARMED
                                          && $past(en) && o_plug_in_detect_n_oe)
        else $error("connection made without an armed enabled state");
    AST_PLUG_SETTLED: assert property (o_plug_in_detect_n_oe |->
                                       s_q.state == HSC_ARMED || s_q.state == HSC_CONN)
        else $error("plug-in detect pulled before start-up finished");
    AST_READY_CONNECTED: assert property (o_ready_oe |-> s_q.state == HSC_CONN)
        else $error("ready pulled while disconnected");
    AST_READY_FOLLOWS: assert property (s_q.state == HSC_CONN |-> o_ready_oe
                                        && o_plug_in_detect_n_oe)
        else $error("ready released while connected");
    AST_QUIET_START: assert property (s_q.state != HSC_CONN |->
                                      s_q.card_oe == '0 && s_q.line_oe == '0)
        else $error("pin driven before connection");
    AST_FIRST_TIMER: assert property (s_q.state == HSC_POWER && supply_ok
                                      && s_q.timer == POWER_LAST |=> s_q.state == HSC_CHECK)
        else $error("first interval did not end in the check state");
    AST_TERM_SETTLE: assert property (s_q.state == HSC_CHECK && supply_ok && term_ok
                                      |=> s_q.state == HSC_SETTLE && s_q.timer == '0)
        else $error("valid termination did not start the second timer");
    AST_ARM_NO_JOIN: assert property (s_q.state == HSC_ARMED && !en |=>
                                      s_q.state != HSC_CONN)
        else $error("joined without enable");
    AST_IDLE_JOIN: assert property (s_armed_idle |=> s_q.state == HSC_CONN)
        else $error("bus idle did not connect");
    AST_LOSS_RESTART: assert property (s_q.state == HSC_CONN && !supply_ok |=>
                                       s_q.state == HSC_POWER ##1 !o_ready_oe)
        else $error("supply loss did not restart start-up");
    AST_ONE_WAY: assert property ((s_q.card_oe & s_q.line_oe) == '0)
        else $error("channel drives both sides at once");

endmodule
`default_nettype wire

// File: logic/hsc_line_rx.sv
// Differential line receiver and stop detector in the line clock domain
`timescale 1ns/10ps
`default_nettype none
module hsc_line_rx (
    input wire logic i_line_clk,
    input wire logic i_reset,
    input wire logic [hsc_pkg::LPIN_W-1:0] i_line_pins,
    output logic [hsc_pkg::NCH-1:0] o_line_level,
    output logic o_stop_toggle
);
    import hsc_pkg::*;

    typedef struct packed {
        logic [LPIN_W-1:0] s1;
        logic [LPIN_W-1:0] s2;
        logic [LPIN_W-1:0] s3;
        logic [LPIN_W-1:0] f;
        logic [NCH-1:0] lvl;
        logic tog;
    } hsc_rx_s_t;

    localparam hsc_rx_s_t RX_RST = '{s1: LPIN_RST, s2: LPIN_RST, s3: LPIN_RST,
                                     f: LPIN_RST, lvl: '1, tog: 1'b0};

    hsc_rx_s_t s_q;
    hsc_rx_s_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.s1 = i_line_pins;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        // A pin change counts once the last two stages agree
        s_d.f = (~(s_q.s2 ^ s_q.s3) & s_q.s3) | ((s_q.s2 ^ s_q.s3) & s_q.f);
        for (int i = 0; i < NCH; i++) begin
            // Only the polarity of plus against minus matters
            s_d.lvl[i] = s_q.f[2*i] & ~s_q.f[2*i+1];
        end
        // Stop: data rises while clock stays high
        if (s_q.lvl[CH_CLOCK] && s_d.lvl[CH_CLOCK] && !s_q.lvl[CH_DATA] && s_d.lvl[CH_DATA]) begin
            s_d.tog = ~s_q.tog;
        end
    end

    always_ff @(posedge i_line_clk or posedge i_reset) begin
        if (i_reset) begin
            s_q <= RX_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_line_level = s_q.lvl;
    assign o_stop_toggle = s_q.tog;

    AST_DIFF_POLARITY: assert property (@(posedge i_line_clk) disable iff (i_reset)
        s_q.f[0] && !s_q.f[1] |=> s_q.lvl[CH_CLOCK])
        else $error("clock level does not follow plus above minus");

endmodule
`default_nettype wire

// File: logic/hsc_pkg.sv
// Shared constants and types for the hot-swap connect controller
package hsc_pkg;

    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_PER_US = CLK_HZ / 1_000_000;

    // Start-up intervals, in microseconds as specified
    localparam int POWER_SETTLE_US = 1000;
    localparam int TERM_SETTLE_US = 10000;
    localparam int POWER_SETTLE_CYC = POWER_SETTLE_US * CLK_PER_US;
    localparam int TERM_SETTLE_CYC = TERM_SETTLE_US * CLK_PER_US;

    // Bus idle time in system clock cycles (10 us at 25 MHz)
    localparam int BUS_IDLE_CYC = 250;
    // Echo blanking after a driver lets go, covers the crossing latency
    localparam int HOLD_CYC = 8;

    localparam int TIMER_W = 18;
    localparam int HOLD_W = 4;

    // Channels
    localparam int NCH = 3;
    localparam int CH_CLOCK = 0;
    localparam int CH_DATA = 1;
    localparam int CH_SIDE = 2;

    // Line pins as seen by the receiver: {side-,side+,data-,data+,clock-,clock+}
    localparam int LPIN_W = 6;
    localparam logic [LPIN_W-1:0] LPIN_RST = 6'h15;

    // Positions in the synchronised input vector of the system domain
    localparam int SY_EN = 0;
    localparam int SY_SUPA = 1;
    localparam int SY_SUPB = 2;
    localparam int SY_TERM_M = 3;
    localparam int SY_TERM_P = 4;
    localparam int SY_CARD = 5;
    localparam int SY_LINE = 8;
    localparam int SY_STOP = 11;
    localparam int SY_W = 12;
    localparam logic [SY_W-1:0] SY_RST = 12'h7e0;

    typedef enum logic [2:0] {
        HSC_POWER,
        HSC_CHECK,
        HSC_SETTLE,
        HSC_ARMED,
        HSC_CONN
    } hsc_state_t;

    typedef enum logic [2:0] {
        HSC_DIR_IDLE,
        HSC_DIR_TO_LINE,
        HSC_DIR_TO_CARD,
        HSC_DIR_HOLD_LINE,
        HSC_DIR_HOLD_CARD
    } hsc_dir_t;

endpackage
